// ==== hdl/tme_engine.sv ====
// Table maintenance engine: register port, staging cache, command sequencer, lookup path.
// Assumes lookups arrive from the frame pipeline already resolved to a row or a miss.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
//Contract
// - Misses use default rows after regular rows
// - Wipe zeroes whole cache, then self-clears
// - Move starts at address, count plus one
// - Move shifts by shift distance exactly
// - Move up decreases, move down increases addresses
// - Skip controls exclude row parts from move
// - Move uses cache; software leaves it alone
// - Move stays hitless, hits still counted
// - Invalidate original source rows after move
// - Lookup restarts current row relocation
// - Ignore control disables lookup restarts
// - Rows shifted below zero are deleted
// - Deletion sets row dropped sticky flag
// - Initialise writes cache to count plus one
// - Skip controls exclude memories from initialise
// - Engine clears trigger when command finishes
// - Copy moves one row cache to/from memory
module tme_engine
  import tme_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // Lookup request from the frame pipeline
  input wire logic lookup_req_i,
  input wire logic lookup_hit_i,
  input wire logic [7:0] lookup_row_i,
  input wire logic [1:0] lookup_default_i,
  // Lookup answer
  output logic lookup_done_o,
  output logic [ACT_W-1:0] lookup_action_o
);
  // Control registers
  logic trig_ff, nxt_trig; // operation_trigger_bit
  tme_cmd_e cmd_ff, nxt_cmd; // Operation select
  logic skip_key_ff, nxt_skip_key; // skip_key_write
  logic skip_act_ff, nxt_skip_act; // skip_action_write
  logic skip_cnt_ff, nxt_skip_cnt; // skip_counter_write
  logic wipe_ff, nxt_wipe; // Wipe-staging request
  logic ign_ff, nxt_ign; // ignore_lookup_restart
  logic [8:0] addr_ff, nxt_addr; // Target row address
  logic [8:0] size_ff, nxt_size; // block_count
  logic [8:0] dist_ff, nxt_dist; // shift_distance
  logic drop_ff, nxt_drop; // row_dropped_flag
  // Staging cache, one replication laid out as a row
  logic [ROW_W-1:0] cache_ff, nxt_cache;
  // Sequencer
  tme_state_e st_ff, nxt_st;
  logic [8:0] idx_ff, nxt_idx; // Row index within the block
  logic restart_ff, nxt_restart; // A lookup raced the current row
  // Lookup pipeline and counter bypass
  logic lk1_ff, nxt_lk1; // Lookup row data arrives this cycle
  logic [8:0] lk1_addr_ff, nxt_lk1_addr;
  logic lastw_ff, nxt_lastw; // Counter written last cycle
  logic [8:0] lastw_addr_ff, nxt_lastw_addr;
  logic [CNT_W-1:0] lastw_cnt_ff, nxt_lastw_cnt;
  logic lk_done_ff, nxt_lk_done;
  logic [ACT_W-1:0] lk_act_ff, nxt_lk_act;
  logic [31:0] rdata_ff, nxt_rdata;
  // Memory port signals
  logic rd_en, wr_en;
  logic [8:0] rd_addr, wr_addr;
  logic [ROW_W-1:0] wr_mask, wr_data, rd_data;
  // Address arithmetic
  logic is_move, is_up, busy, dst_bad, in_win, blocked, last_row;
  logic [8:0] lk_addr, row_addr;
  logic [9:0] src_w;
  logic signed [11:0] dst_s, win_lo, win_hi, inv_s;
  logic [ROW_W-1:0] part_mask;
  logic [CNT_W-1:0] cnt_old;

  assign busy = trig_ff;
  assign is_move = (cmd_ff == CMD_MOVE_UP) || (cmd_ff == CMD_MOVE_DOWN);
  assign is_up = (cmd_ff == CMD_MOVE_UP);
  assign last_row = (idx_ff == size_ff);
  // Misses land on the default rows that follow the regular ones
  assign lk_addr = lookup_hit_i ? {1'b0, lookup_row_i} : DEF_BASE + {7'h00, lookup_default_i};

  // Source, destination and leftover window of a move
  always_comb begin
    // Down walks from the top so no row is overwritten before it is read
    if (is_move && !is_up) begin
      src_w = {1'b0, addr_ff} + {1'b0, size_ff} - {1'b0, idx_ff};
    end else begin
      src_w = {1'b0, addr_ff} + {1'b0, idx_ff};
    end
    row_addr = src_w[8:0];
    if (is_up) begin
      dst_s = $signed({2'b00, src_w}) - $signed({3'b000, dist_ff});
      win_lo = $signed({3'b000, addr_ff}) - $signed({3'b000, dist_ff});
    end else begin
      dst_s = $signed({2'b00, src_w}) + $signed({3'b000, dist_ff});
      win_lo = $signed({3'b000, addr_ff}) + $signed({3'b000, dist_ff});
    end
    win_hi = win_lo + $signed({3'b000, size_ff});
    inv_s = $signed({2'b00, src_w});
    in_win = (inv_s >= win_lo) && (inv_s <= win_hi);
    // Below zero is deleted; past the table end is dropped the same way
    dst_bad = dst_s[11] || (dst_s[10:0] > LAST_ROW);
    part_mask = (skip_key_ff ? '0 : M_KEY) | (skip_act_ff ? '0 : M_ACT)
              | (skip_cnt_ff ? '0 : M_CNT);
  end

  // Sequencer, control and sticky registers
  always_comb begin
    nxt_trig = trig_ff;
    nxt_cmd = cmd_ff;
    nxt_skip_key = skip_key_ff;
    nxt_skip_act = skip_act_ff;
    nxt_skip_cnt = skip_cnt_ff;
    nxt_wipe = 1'b0;
    nxt_ign = ign_ff;
    nxt_addr = addr_ff;
    nxt_size = size_ff;
    nxt_dist = dist_ff;
    nxt_drop = drop_ff;
    nxt_st = st_ff;
    nxt_idx = idx_ff;
    nxt_restart = restart_ff;
    wr_en = 1'b0;
    wr_addr = row_addr;
    wr_mask = part_mask;
    wr_data = cache_ff;
    // Lookup wins the write port; the row write waits a cycle
    blocked = lk1_ff;
    // Sticky flag: write one clears, a same-cycle drop below wins
    if (reg_we_i && reg_addr_i == OFS_STICKY && reg_wdata_i[ST_DROP]) begin
      nxt_drop = 1'b0;
    end
    // A new command is taken only while idle
    if (reg_we_i && !busy) begin
      if (reg_addr_i == OFS_UPD_CTRL) begin
        nxt_trig = reg_wdata_i[UC_TRIG];
        nxt_cmd = tme_cmd_e'(reg_wdata_i[UC_CMD_LSB +: 3]);
        nxt_skip_key = reg_wdata_i[UC_SKIP_KEY];
        nxt_skip_act = reg_wdata_i[UC_SKIP_ACT];
        nxt_skip_cnt = reg_wdata_i[UC_SKIP_CNT];
        nxt_wipe = reg_wdata_i[UC_WIPE];
        nxt_ign = reg_wdata_i[UC_IGN];
        nxt_addr = reg_wdata_i[UC_ADDR_LSB +: 9];
      end else if (reg_addr_i == OFS_MOVE_CFG) begin
        nxt_size = reg_wdata_i[MC_SIZE_LSB +: 9];
        nxt_dist = reg_wdata_i[MC_DIST_LSB +: 9];
      end
    end
    case (st_ff)
      // Wait for the trigger
      ST_IDLE: begin
        nxt_idx = 9'h000;
        nxt_restart = 1'b0;
        if (trig_ff) begin
          if (cmd_ff == CMD_TO_MEM || cmd_ff == CMD_INIT) begin
            nxt_st = ST_WR;
          end else if (cmd_ff == CMD_TO_CACHE || is_move) begin
            nxt_st = ST_RD;
          end else begin
            nxt_st = ST_DONE; // Unknown command finishes at once
          end
        end
      end
      // Read issued only when no lookup holds the read port
      ST_RD: begin
        nxt_restart = 1'b0;
        if (!lookup_req_i) begin
          nxt_st = ST_RWAIT;
        end
      end
      // Row lands in the cache; earlier contents are lost
      ST_RWAIT: begin
        nxt_restart = lk1_ff;
        nxt_st = (cmd_ff == CMD_TO_CACHE) ? ST_DONE : ST_WR;
      end
      // Write one row, or drop it, or restart it
      ST_WR: begin
        if (is_move) begin
          wr_addr = dst_s[8:0];
        end
        if (is_move && dst_bad) begin
          nxt_drop = 1'b1;
        end
        if (is_move && !ign_ff && !dst_bad
            && (restart_ff || lk1_ff || lookup_req_i)) begin
          nxt_st = ST_RD;
        end else if (!(blocked && !(is_move && dst_bad))) begin
          wr_en = !(is_move && dst_bad);
          if (last_row || cmd_ff == CMD_TO_MEM) begin
            nxt_idx = 9'h000;
            nxt_st = is_move ? ST_INV : ST_DONE;
          end else begin
            nxt_idx = idx_ff + 9'h001;
            nxt_st = is_move ? ST_RD : ST_WR;
          end
        end
      end
      // Invalidate source rows that no destination covers
      ST_INV: begin
        wr_mask = M_TG;
        wr_data = RST_ROW;
        if (!blocked) begin
          wr_en = !skip_key_ff && !in_win;
          nxt_idx = idx_ff + 9'h001;
          if (last_row) begin
            nxt_st = ST_DONE;
          end
        end
      end
      // Self-clear of the trigger
      ST_DONE: begin
        nxt_trig = 1'b0;
        nxt_st = ST_IDLE;
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
    // Lookup counter update owns the write port
    if (lk1_ff) begin
      wr_en = 1'b1;
      wr_addr = lk1_addr_ff;
      wr_mask = M_CNT;
      wr_data = {{TG_W{1'b0}}, cnt_old + 16'h0001, {(ACT_W + 2 * KEY_W){1'b0}}};
    end
  end

  // Staging cache: wipe, then row load, then register writes
  always_comb begin
    nxt_cache = cache_ff;
    if (wipe_ff) begin
      nxt_cache = RST_ROW;
    end else if (st_ff == ST_RWAIT) begin
      nxt_cache = rd_data;
    end else if (reg_we_i && !busy) begin
      case (reg_addr_i)
        OFS_KEY: nxt_cache[KEY_LSB +: KEY_W] = reg_wdata_i;
        OFS_MASK: nxt_cache[MASK_LSB +: KEY_W] = reg_wdata_i;
        OFS_ACT: nxt_cache[ACT_LSB +: ACT_W] = reg_wdata_i;
        OFS_CNT: nxt_cache[CNT_LSB +: CNT_W] = reg_wdata_i[CNT_W-1:0];
        OFS_TG: nxt_cache[TG_LSB +: TG_W] = reg_wdata_i[TG_W-1:0];
        default: nxt_cache = cache_ff;
      endcase
    end
  end

  // Lookup path, counter bypass and register read data
  always_comb begin
    rd_en = lookup_req_i || (st_ff == ST_RD);
    rd_addr = lookup_req_i ? lk_addr : row_addr;
    nxt_lk1 = lookup_req_i;
    nxt_lk1_addr = lk_addr;
    // Last cycle's counter write is not yet visible in the read data
    cnt_old = rd_data[CNT_LSB +: CNT_W];
    if (lastw_ff && lastw_addr_ff == lk1_addr_ff) begin
      cnt_old = lastw_cnt_ff;
    end
    nxt_lastw = wr_en && (wr_mask[CNT_LSB] == 1'b1);
    nxt_lastw_addr = wr_addr;
    nxt_lastw_cnt = wr_data[CNT_LSB +: CNT_W];
    nxt_lk_done = lk1_ff;
    nxt_lk_act = lk1_ff ? rd_data[ACT_LSB +: ACT_W] : lk_act_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_re_i) begin
      case (reg_addr_i)
        OFS_UPD_CTRL: nxt_rdata = {7'h00, addr_ff, 7'h00, ign_ff, wipe_ff, skip_cnt_ff,
                                   skip_act_ff, skip_key_ff, cmd_ff, trig_ff};
        OFS_MOVE_CFG: nxt_rdata = {7'h00, dist_ff, 7'h00, size_ff};
        OFS_STICKY: nxt_rdata = {31'h0000_0000, drop_ff};
        OFS_KEY: nxt_rdata = cache_ff[KEY_LSB +: KEY_W];
        OFS_MASK: nxt_rdata = cache_ff[MASK_LSB +: KEY_W];
        OFS_ACT: nxt_rdata = cache_ff[ACT_LSB +: ACT_W];
        OFS_CNT: nxt_rdata = {16'h0000, cache_ff[CNT_LSB +: CNT_W]};
        OFS_TG: nxt_rdata = {30'h0000_0000, cache_ff[TG_LSB +: TG_W]};
        OFS_STATUS: nxt_rdata = {26'h000_0000, st_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // All registers of the engine
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      trig_ff <= 1'b0;
      cmd_ff <= CMD_TO_MEM;
      skip_key_ff <= 1'b0;
      skip_act_ff <= 1'b0;
      skip_cnt_ff <= 1'b0;
      wipe_ff <= 1'b0;
      ign_ff <= 1'b0;
      addr_ff <= RST_ADDR;
      size_ff <= RST_ADDR;
      dist_ff <= RST_ADDR;
      drop_ff <= 1'b0;
      cache_ff <= RST_ROW;
      st_ff <= ST_IDLE;
      idx_ff <= RST_ADDR;
      restart_ff <= 1'b0;
      lk1_ff <= 1'b0;
      lk1_addr_ff <= RST_ADDR;
      lastw_ff <= 1'b0;
      lastw_addr_ff <= RST_ADDR;
      lastw_cnt_ff <= '0;
      lk_done_ff <= 1'b0;
      lk_act_ff <= '0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      trig_ff <= nxt_trig;
      cmd_ff <= nxt_cmd;
      skip_key_ff <= nxt_skip_key;
      skip_act_ff <= nxt_skip_act;
      skip_cnt_ff <= nxt_skip_cnt;
      wipe_ff <= nxt_wipe;
      ign_ff <= nxt_ign;
      addr_ff <= nxt_addr;
      size_ff <= nxt_size;
      dist_ff <= nxt_dist;
      drop_ff <= nxt_drop;
      cache_ff <= nxt_cache;
      st_ff <= nxt_st;
      idx_ff <= nxt_idx;
      restart_ff <= nxt_restart;
      lk1_ff <= nxt_lk1;
      lk1_addr_ff <= nxt_lk1_addr;
      lastw_ff <= nxt_lastw;
      lastw_addr_ff <= nxt_lastw_addr;
      lastw_cnt_ff <= nxt_lastw_cnt;
      lk_done_ff <= nxt_lk_done;
      lk_act_ff <= nxt_lk_act;
      rdata_ff <= nxt_rdata;
    end
  end

  // Row store
  tme_row_mem u_mem (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .rd_en_i(rd_en),
    .rd_addr_i(rd_addr),
    .rd_data_o(rd_data),
    .wr_en_i(wr_en),
    .wr_addr_i(wr_addr),
    .wr_mask_i(wr_mask),
    .wr_data_i(wr_data)
  );

  assign reg_rdata_o = rdata_ff;
  assign lookup_done_o = lk_done_ff;
  assign lookup_action_o = lk_act_ff;

  // Checks
  property p_miss_default;
    @(posedge clk_i) disable iff (!resetn_i)
    lookup_req_i && !lookup_hit_i |=> lk1_addr_ff == DEF_BASE + {7'h00, $past(lookup_default_i)};
  endproperty
  a_miss_default: assert property (p_miss_default) else $error("miss not on default row");
  property p_wipe;
    @(posedge clk_i) disable iff (!resetn_i)
    wipe_ff |=> (cache_ff == RST_ROW) && !wipe_ff;
  endproperty
  a_wipe: assert property (p_wipe) else $error("wipe did not clear cache");
  property p_done;
    @(posedge clk_i) disable iff (!resetn_i)
    st_ff == ST_DONE |=> !trig_ff && st_ff == ST_IDLE;
  endproperty
  a_done: assert property (p_done) else $error("trigger not cleared at end");
  property p_restart;
    @(posedge clk_i) disable iff (!resetn_i)
    // A lookup counter write may own the port in the same cycle
    st_ff == ST_WR && is_move && !ign_ff && !dst_bad && lookup_req_i
      |-> (lk1_ff || !wr_en) ##1 st_ff == ST_RD;
  endproperty
  a_restart: assert property (p_restart) else $error("row not restarted on lookup");
  property p_drop;
    @(posedge clk_i) disable iff (!resetn_i)
    st_ff == ST_WR && is_move && dst_bad |-> (lk1_ff || !wr_en) ##1 drop_ff;
  endproperty
  a_drop: assert property (p_drop) else $error("dropped row not flagged");
  property p_lookup_first;
    @(posedge clk_i) disable iff (!resetn_i)
    lk1_ff |-> wr_en && wr_mask == M_CNT && wr_addr == lk1_addr_ff;
  endproperty
  a_lookup_first: assert property (p_lookup_first) else $error("lookup lost write port");
  property p_busy_cfg;
    @(posedge clk_i) disable iff (!resetn_i)
    busy && reg_we_i && reg_addr_i == OFS_MOVE_CFG |=> $stable(size_ff) && $stable(dist_ff);
  endproperty
  a_busy_cfg: assert property (p_busy_cfg) else $error("config taken while busy");
  property p_skip_act;
    @(posedge clk_i) disable iff (!resetn_i)
    wr_en && !lk1_ff && skip_act_ff |-> (wr_mask & M_ACT) == RST_ROW;
  endproperty
  a_skip_act: assert property (p_skip_act) else $error("action written while skipped");
  property p_inval;
    @(posedge clk_i) disable iff (!resetn_i)
    st_ff == ST_INV && wr_en && !lk1_ff |-> wr_mask == M_TG && !in_win && !skip_key_ff;
  endproperty
  a_inval: assert property (p_inval) else $error("bad invalidation write");
endmodule : tme_engine

// ==== inc/tme_pkg.sv ====
// Constants, field layouts and state encodings of the table maintenance engine.
// Assumes one core clock; every file of the engine imports this package whole.
package tme_pkg;
  // Row field widths
  localparam int unsigned KEY_W = 32;
  localparam int unsigned ACT_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned TG_W = 2;
  localparam int unsigned ROW_W = 2 * KEY_W + ACT_W + CNT_W + TG_W;
  // Field positions inside one stored row
  localparam int unsigned KEY_LSB = 0;
  localparam int unsigned MASK_LSB = 32;
  localparam int unsigned ACT_LSB = 64;
  localparam int unsigned CNT_LSB = 96;
  localparam int unsigned TG_LSB = 112;
  // Table geometry: regular rows, then the default-action rows
  localparam int unsigned NUM_REGULAR = 256;
  localparam int unsigned NUM_DEFAULT = 4;
  localparam int unsigned DEPTH = NUM_REGULAR + NUM_DEFAULT;
  localparam int unsigned ADDR_W = 9;
  localparam logic [8:0] DEF_BASE = 9'h100;
  localparam logic [10:0] LAST_ROW = 11'h103;
  // Write masks of the three row parts, then of the type group alone; the type group goes with the key
  localparam logic [ROW_W-1:0] M_KEY = {{TG_W{1'b1}}, {(CNT_W + ACT_W){1'b0}}, {(2 * KEY_W){1'b1}}};
  localparam logic [ROW_W-1:0] M_ACT = {{(TG_W + CNT_W){1'b0}}, {ACT_W{1'b1}}, {(2 * KEY_W){1'b0}}};
  localparam logic [ROW_W-1:0] M_CNT = {{TG_W{1'b0}}, {CNT_W{1'b1}}, {(ACT_W + 2 * KEY_W){1'b0}}};
  localparam logic [ROW_W-1:0] M_TG = {{TG_W{1'b1}}, {(ROW_W - TG_W){1'b0}}};
  // Register byte offsets
  localparam logic [7:0] OFS_UPD_CTRL = 8'h00;
  localparam logic [7:0] OFS_MOVE_CFG = 8'h04;
  localparam logic [7:0] OFS_STICKY = 8'h08;
  localparam logic [7:0] OFS_KEY = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_ACT = 8'h14;
  localparam logic [7:0] OFS_CNT = 8'h18;
  localparam logic [7:0] OFS_TG = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // update_control bit positions
  localparam int unsigned UC_TRIG = 0;
  localparam int unsigned UC_CMD_LSB = 1;
  localparam int unsigned UC_SKIP_KEY = 4;
  localparam int unsigned UC_SKIP_ACT = 5;
  localparam int unsigned UC_SKIP_CNT = 6;
  localparam int unsigned UC_WIPE = 7;
  localparam int unsigned UC_IGN = 8;
  localparam int unsigned UC_ADDR_LSB = 16;
  // move_config and sticky_flags bit positions
  localparam int unsigned MC_SIZE_LSB = 0;
  localparam int unsigned MC_DIST_LSB = 16;
  localparam int unsigned ST_DROP = 0;
  // Reset values
  localparam logic [8:0] RST_ADDR = 9'h000;
  localparam logic [ROW_W-1:0] RST_ROW = '0;
  // Commands carried in update_control
  typedef enum logic [2:0] {
    CMD_TO_MEM = 3'h0,
    CMD_TO_CACHE = 3'h1,
    CMD_MOVE_UP = 3'h2,
    CMD_MOVE_DOWN = 3'h3,
    CMD_INIT = 3'h4
  } tme_cmd_e;
  // Engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RD = 6'h02,
    ST_RWAIT = 6'h04,
    ST_WR = 6'h08,
    ST_INV = 6'h10,
    ST_DONE = 6'h20
  } tme_state_e;
endpackage : tme_pkg

// ==== hdl/tme_row_mem.sv ====
// Row store of the engine: key, mask, action, counter and type group per row.
// Assumes one read and one masked write per clock; read data one cycle later.
`timescale 1ns/1ps
module tme_row_mem
  import tme_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Read port
  input wire logic rd_en_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [ROW_W-1:0] rd_data_o,
  // Masked write port
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [ROW_W-1:0] wr_mask_i,
  input wire logic [ROW_W-1:0] wr_data_i
);
  logic [ROW_W-1:0] mem [DEPTH]; // Storage, no reset: rows hold garbage until written
  logic [ROW_W-1:0] rd_data_ff; // Registered read data
  logic [ROW_W-1:0] nxt_rd_data; // Next read data

  // Read before write: a same-cycle write is not seen until the next read
  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (rd_en_i && (32'(rd_addr_i) < DEPTH)) begin
      nxt_rd_data = mem[rd_addr_i];
    end
  end

  // Read register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_data_ff <= RST_ROW;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Bitwise masked write, whole row in one edge so no reader sees half of it
  always_ff @(posedge clk_i) begin
    if (wr_en_i && (32'(wr_addr_i) < DEPTH)) begin
      mem[wr_addr_i] <= (mem[wr_addr_i] & ~wr_mask_i) | (wr_data_i & wr_mask_i);
    end
  end

  assign rd_data_o = rd_data_ff;
endmodule : tme_row_mem

// ==== verification/tme_engine_tb.sv ====
// Self-checking bench of the table maintenance engine, with a row and cache model.
// Assumes the engine alone; the bench drives its register and lookup ports.
`timescale 1ns/1ps
module testbench
  import tme_pkg::*;
;
  // Design ports
  logic clk_i;
  logic resetn_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_we_i;
  logic reg_re_i;
  logic [31:0] reg_rdata_o;
  logic lookup_req_i;
  logic lookup_hit_i;
  logic [7:0] lookup_row_i;
  logic [1:0] lookup_default_i;
  logic lookup_done_o;
  logic [ACT_W-1:0] lookup_action_o;
  // Model rows and cache, packed like the stored row
  logic [ROW_W-1:0] mrow[DEPTH];
  logic [ROW_W-1:0] mc;
  int n_mismatch = 0;
  int total_checks = 0;
  logic h;

  tme_engine u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .lookup_req_i(lookup_req_i), .lookup_hit_i(lookup_hit_i),
    .lookup_row_i(lookup_row_i), .lookup_default_i(lookup_default_i),
    .lookup_done_o(lookup_done_o), .lookup_action_o(lookup_action_o));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic conclude();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk

  // One-cycle write, then one idle cycle so strobes never toggle twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string s);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 chk(s, e, reg_rdata_o);
    @(posedge clk_i);
  endtask : rchk

  // Write enables of the row parts; f = {ignore, skip_cnt, skip_act, skip_key}
  function automatic logic [ROW_W-1:0] wm(input logic [3:0] f);
    return (f[0] ? '0 : M_KEY) | (f[1] ? '0 : M_ACT) | (f[2] ? '0 : M_CNT);
  endfunction : wm

  task automatic put(input int r, input logic [3:0] f);
    mrow[r] = (mrow[r] & ~wm(f)) | (mc & wm(f));
  endtask : put

  // Fresh random cache; mask is the key inverted so readback is never remapped
  task automatic fill();
    logic [31:0] k;
    k = $urandom;
    mc = {2'($urandom), 16'($urandom), 32'($urandom), ~k, k};
    wr(OFS_KEY, mc[31:0]);
    wr(OFS_MASK, mc[63:32]);
    wr(OFS_ACT, mc[95:64]);
    wr(OFS_CNT, {16'h0, mc[111:96]});
    wr(OFS_TG, {30'h0, mc[113:112]});
  endtask : fill

  task automatic cchk();
    rchk(OFS_KEY, mc[31:0], "key");
    rchk(OFS_MASK, mc[63:32], "mask");
    rchk(OFS_ACT, mc[95:64], "action");
    rchk(OFS_CNT, {16'h0, mc[111:96]}, "counter");
    rchk(OFS_TG, {30'h0, mc[113:112]}, "type_group");
  endtask : cchk

  task automatic start(input tme_cmd_e c, input int a, input logic [3:0] f);
    wr(OFS_UPD_CTRL, {7'h0, 9'(a), 7'h0, f[3], 1'b0, f[2:0], c, 1'b1});
  endtask : start

  // Poll the trigger under a bound; a hang shows as a mismatch
  task automatic fin();
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      reg_addr_i <= OFS_UPD_CTRL;
      reg_re_i <= 1'b1;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      #1 d = reg_rdata_o;
      @(posedge clk_i);
      n++;
    end while (d[0] !== 1'b0 && n < 3000);
    chk("trigger", 32'h0, {31'h0, d[0]});
  endtask : fin

  task automatic cmd(input tme_cmd_e c, input int a, input logic [3:0] f);
    start(c, a, f);
    fin();
  endtask : cmd

  task automatic rowchk(input int r);
    cmd(CMD_TO_CACHE, r, 4'h0);
    mc = mrow[r];
    cchk();
  endtask : rowchk

  // Block move in the model: sources are read before any destination is written
  task automatic mv(input int a, input int n, input int s, input bit up, input logic [3:0] f);
    logic [ROW_W-1:0] t[$];
    int b;
    b = up ? a - s : a + s;
    for (int i = 0; i <= n; i++) t.push_back(mrow[a + i]);
    for (int i = 0; i <= n; i++)
      if (b + i >= 0 && b + i < int'(DEPTH)) mrow[b + i] = (mrow[b + i] & ~wm(f)) | (t[i] & wm(f));
    for (int r = a; r <= a + n; r++)
      if ((r < b || r > b + n) && !f[0]) mrow[r][TG_LSB +: TG_W] = 2'h0;
  endtask : mv

  // Lookup: done and action two cycles after the request; that row's counter +1
  task automatic look(input logic hit, input int r);
    int x;
    x = hit ? r : 256 + r;
    lookup_hit_i <= hit;
    lookup_row_i <= 8'(r);
    lookup_default_i <= 2'(r);
    lookup_req_i <= 1'b1;
    @(posedge clk_i);
    lookup_req_i <= 1'b0;
    @(posedge clk_i);
    #1 chk("lookup_done", 32'h1, {31'h0, lookup_done_o});
    chk("lookup_action", mrow[x][ACT_LSB +: ACT_W], lookup_action_o);
    mrow[x][CNT_LSB +: CNT_W] += 1'b1;
    @(posedge clk_i);
  endtask : look

  // Watchdog, far beyond the thousand or so cycles the sequence needs
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end

  // Main sequence
  initial begin
    {resetn_i, reg_we_i, reg_re_i, lookup_req_i, lookup_hit_i} = '0;
    {reg_addr_i, reg_wdata_i, lookup_row_i, lookup_default_i} = '0;
    void'($urandom(32'h5c66));
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rchk(OFS_STATUS, 32'h1, "status");
    rchk(8'h24, 32'h0, "unmapped");
    wr(8'h24, 32'hffffffff);
    fill();
    wr(OFS_UPD_CTRL, 32'h80);
    mc = '0;
    cchk();
    rchk(OFS_UPD_CTRL, 32'h0, "wipe_bit");
    // Whole table from the cache; busy engine must ignore config and cache writes
    fill();
    wr(OFS_MOVE_CFG, 32'd259);
    start(CMD_INIT, 0, 4'h0);
    wr(OFS_MOVE_CFG, 32'h5);
    wr(OFS_KEY, ~mc[31:0]);
    fin();
    rchk(OFS_MOVE_CFG, 32'd259, "move_config");
    cchk();
    for (int r = 0; r < int'(DEPTH); r++) put(r, 4'h0);
    // Partial initialise without the action part; neighbours stay untouched
    fill();
    wr(OFS_MOVE_CFG, 32'd3);
    cmd(CMD_INIT, 100, 4'h2);
    for (int r = 100; r <= 103; r++) put(r, 4'h2);
    for (int r = 99; r <= 104; r++) rowchk(r);
    rowchk(259);
    // Default action copy keeps the key part out
    fill();
    cmd(CMD_TO_MEM, 257, 4'h1);
    put(257, 4'h1);
    repeat (24) begin
      h = 1'($urandom);
      look(h, h ? int'($urandom % 256) : int'($urandom % 4));
    end
    rowchk(257);
    // Distinct rows for the moves
    for (int r = 1; r <= 12; r++) begin
      fill();
      cmd(CMD_TO_MEM, r, 4'h0);
      put(r, 4'h0);
    end
    wr(OFS_MOVE_CFG, {7'h0, 9'd2, 7'h0, 9'd2});
    fork
      cmd(CMD_MOVE_DOWN, 10, 4'h4);
      repeat (4) look(1'b1, 200);
    join
    mv(10, 2, 2, 1'b0, 4'h4);
    for (int r = 8; r <= 16; r++) rowchk(r);
    rowchk(200);
    rchk(OFS_STICKY, 32'h0, "sticky");
    // Move up past row 0 with restarts off: one row is dropped
    fork
      cmd(CMD_MOVE_UP, 1, 4'ha);
      repeat (4) look(1'b0, 2);
    join
    mv(1, 2, 2, 1'b1, 4'ha);
    for (int r = 0; r <= 4; r++) rowchk(r);
    rchk(OFS_STICKY, 32'h1, "sticky");
    wr(OFS_STICKY, 32'h1);
    rchk(OFS_STICKY, 32'h0, "sticky");
    // Default rows down by one, key kept out; the top row falls off the table
    wr(OFS_MOVE_CFG, {7'h0, 9'd1, 7'h0, 9'd1});
    cmd(CMD_MOVE_DOWN, 258, 4'h1);
    mv(258, 1, 1, 1'b0, 4'h1);
    for (int r = 256; r <= 259; r++) rowchk(r);
    rchk(OFS_STICKY, 32'h1, "sticky");
    // An undefined command only clears the trigger
    cmd(tme_cmd_e'(3'h5), 0, 4'h0);
    rowchk(0);
    conclude();
  end
endmodule : testbench
